// >>> hdl/rssf_avg.sv
// Power-of-two running average of an 8-bit strength sample.
// Assumes samples arrive as single-cycle strobes on the same clock.
`include "rssf_cfg.svh"
module rssf_avg (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clr,
    input wire logic smp_vld,
    input wire logic [7:0] smp,
    input wire logic [2:0] log_len,
    output logic [7:0] avg_q
);
    logic [16:0] acc_q;
    logic [16:0] acc_d;
    logic [3:0] shift;
    always_comb begin
        shift = {1'b0, log_len} + 4'h1;
        // Leaky accumulator: acc holds avg * 2^shift, a running mean
        acc_d = acc_q - (acc_q >> shift) + {9'h000, smp};
    end
    always_ff @(posedge sys_clk) begin
        if (rst || (ce && clr)) begin
            acc_q <= 17'h00000;
            avg_q <= 8'h00;
        end else if (ce && smp_vld) begin
            acc_q <= acc_d;
            avg_q <= 8'((acc_d >> shift));
        end
    end
endmodule

// >>> hdl/rssf_cfg.svh
// Constants for the receive strength and channel filter block.
// Assumes inclusion by bare name from the design files.
`ifndef RSSF_CFG_SVH
`define RSSF_CFG_SVH
`define RSSF_ADDR_CTRL 12'h000
`define RSSF_ADDR_THR_LO 12'h004
`define RSSF_ADDR_THR_HI 12'h008
`define RSSF_ADDR_BW 12'h00c
`define RSSF_ADDR_KEYED 12'h010
`define RSSF_ADDR_SPREAD 12'h014
`define RSSF_ADDR_STATUS 12'h018
`define RSSF_ADDR_COEF 12'h040
`define RSSF_CTRL_RX_EN 0
`define RSSF_CTRL_CAL 1
`define RSSF_CTRL_AVG_LSB 4
`define RSSF_CTRL_OFS_LSB 8
`define RSSF_BW_EXP_LSB 0
`define RSSF_BW_MANT_LSB 4
`define RSSF_CTRL_RESET 32'h0000_0000
`define RSSF_THR_LO_RESET 32'h60_70_80_90
`define RSSF_THR_HI_RESET 32'h0000_0050
`define RSSF_BW_RESET 32'h0000_0005
`define RSSF_TAPS 16
`define RSSF_CAL_NS 1000
`define RSSF_CLK_MHZ 200
`define RSSF_CAL_CYC ((`RSSF_CAL_NS * `RSSF_CLK_MHZ + 999) / 1000)
`define RSSF_PKT_AVG_LOG 3
`endif

// >>> hdl/rssf_fir.sv
// Sixteen-tap FIR channel filter with programmable signed coefficients.
// Assumes one I or Q sample per strobe; coefficients from the register file.
`include "rssf_cfg.svh"
module rssf_fir (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_vld,
    input wire logic signed [11:0] in_smp,
    input wire logic [16*8-1:0] coefs,
    output logic out_vld_q,
    output logic signed [11:0] out_q
);
    logic signed [11:0] dl_q [0:`RSSF_TAPS-1];
    logic signed [23:0] sum;
    always_comb begin
        sum = 24'sh000000;
        for (int i = 0; i < `RSSF_TAPS; i++) begin
            sum = sum + 24'(dl_q[i] * $signed(coefs[i*8 +: 8]));
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < `RSSF_TAPS; i++) begin
                dl_q[i] <= 12'sh000;
            end
        end else if (ce && in_vld) begin
            dl_q[0] <= in_smp;
            for (int i = 1; i < `RSSF_TAPS; i++) begin
                dl_q[i] <= dl_q[i-1];
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_vld_q <= 1'b0;
            out_q <= 12'sh000;
        end else if (ce) begin
            out_vld_q <= in_vld;
            if (in_vld) begin
                out_q <= sum[18:7];
            end
        end
    end
endmodule

// >>> hdl/rssf_pkg.sv
// Types shared by the receive strength and channel filter block.
// Assumes no other package.
package rssf_pkg;
    typedef enum logic [1:0] {
        RSSF_IDLE = 2'b00,
        RSSF_ENABLED = 2'b01,
        RSSF_ACTIVE = 2'b11,
        RSSF_CALIB = 2'b10
    } rssf_state_e;
    typedef logic [7:0] rssf_level_t;
endpackage

// >>> hdl/rssf_top.sv
// Receive strength measurement, gain stepping and channel filter, APB slave.
// Assumes level and sample inputs come from front-end logic on sys_clk;
// packet events arrive from other logic as pins and are synchronised here.
//
// Functional notes
// - Gain step from five ascending thresholds: codes 001,010,011,100,110,111.
// - Keyed strength equals minus twice input dBm plus offset, half-dB steps.
// - Offset is signed whole dB, -16 to +15, added into strength.
// - Averaging length is two to the power (field plus one) samples.
// - Response time is sample count over four times bandwidth in kHz.
// - Strength calibration runs whenever image and strength calibration starts.
// - Instantaneous spread value always readable; packet value averages it.
// - Channel filter is a sixteen-tap FIR.
// - Bandwidth is oscillator over mantissa times two to exponent plus two.
// - Mantissa 00/01/10 decode 16/20/24; exponent 1..7 valid, rest reserved.
// - Receive waits enabled until preamble or strength criterion, then active.
`include "rssf_cfg.svh"
module rssf_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lvl_vld,
    input wire logic [7:0] in_level_neg2,
    input wire logic [7:0] spread_inst,
    input wire logic [7:0] packet_noise_ratio,
    input wire logic preamble_ok,
    input wire logic header_ok_event,
    input wire logic receive_done_event,
    input wire logic smp_vld,
    input wire logic signed [11:0] smp_i,
    input wire logic signed [11:0] smp_q,
    output logic [2:0] amp_gain_step,
    output logic [2:0] amp_rel_gain_idx,
    output logic filt_vld,
    output logic signed [11:0] filt_i,
    output logic signed [11:0] filt_q,
    output logic [2:0] bandwidth_exponent,
    output logic [4:0] bandwidth_divider,
    output logic bandwidth_reserved,
    output logic rx_active
);
    logic [31:0] ctrl_q;
    logic [31:0] thr_lo_q;
    logic [31:0] thr_hi_q;
    logic [31:0] bw_q;
    logic [127:0] coef_q;
    logic [7:0] keyed_strength_value;
    logic [7:0] packet_strength;
    logic [7:0] keyed_q;
    logic keyed_vld_q;
    logic [7:0] spread_inst_q;
    logic [7:0] snr_q;
    logic [2:0] gain_d;
    logic [1:0] bandwidth_mantissa;
    logic [4:0] strength_comp_offset;
    logic [2:0] strength_avg_length;
    logic [7:0] gain_threshold_1;
    logic [7:0] gain_threshold_2;
    logic [7:0] gain_threshold_3;
    logic [7:0] gain_threshold_4;
    logic [7:0] gain_threshold_5;
    logic [1:0] hdr_s1_q;
    logic [1:0] hdr_s2_q;
    logic [1:0] hdr_s3_q;
    logic pre_s1_q;
    logic pre_s2_q;
    logic in_payload_q;
    logic cal_pend_q;
    logic [$clog2(`RSSF_CAL_CYC+1)-1:0] cal_cnt_q;
    logic wr;
    logic rd;
    logic f_vld_q;
    rssf_pkg::rssf_state_e st_q;
    rssf_pkg::rssf_state_e st_d;

    assign wr = psel && penable && pwrite && ce;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;

    assign strength_avg_length = ctrl_q[`RSSF_CTRL_AVG_LSB +: 3];
    assign strength_comp_offset = ctrl_q[`RSSF_CTRL_OFS_LSB +: 5];
    assign gain_threshold_1 = thr_lo_q[31:24];
    assign gain_threshold_2 = thr_lo_q[23:16];
    assign gain_threshold_3 = thr_lo_q[15:8];
    assign gain_threshold_4 = thr_lo_q[7:0];
    assign gain_threshold_5 = thr_hi_q[7:0];
    assign bandwidth_mantissa = bw_q[`RSSF_BW_MANT_LSB +: 2];
    assign bandwidth_exponent = bw_q[`RSSF_BW_EXP_LSB +: 3];

    // Registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= `RSSF_CTRL_RESET;
            thr_lo_q <= `RSSF_THR_LO_RESET;
            thr_hi_q <= `RSSF_THR_HI_RESET;
            bw_q <= `RSSF_BW_RESET;
            coef_q <= {16{8'h10}};
        end else begin
            if (wr) begin
                case (paddr)
                    `RSSF_ADDR_CTRL: ctrl_q <= {19'h00000, pwdata[12:8], 1'b0, pwdata[6:4], 2'h0, pwdata[1:0]};
                    `RSSF_ADDR_THR_LO: thr_lo_q <= pwdata;
                    `RSSF_ADDR_THR_HI: thr_hi_q <= {24'h000000, pwdata[7:0]};
                    `RSSF_ADDR_BW: bw_q <= {26'h0000000, pwdata[5:4], 1'b0, pwdata[2:0]};
                    default: begin
                        if (paddr >= `RSSF_ADDR_COEF && paddr < 12'h080 && paddr[1:0] == 2'b00) begin
                            coef_q[paddr[5:2]*8 +: 8] <= pwdata[7:0];
                        end
                    end
                endcase
            end
            // Calibration start self-clears; a control write in the same cycle wins
            if (ce && cal_pend_q && !(wr && paddr == `RSSF_ADDR_CTRL)) begin
                ctrl_q[`RSSF_CTRL_CAL] <= 1'b0;
            end
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (rd) begin
            case (paddr)
                `RSSF_ADDR_CTRL: prdata = ctrl_q;
                `RSSF_ADDR_THR_LO: prdata = thr_lo_q;
                `RSSF_ADDR_THR_HI: prdata = thr_hi_q;
                `RSSF_ADDR_BW: prdata = {16'h0000, 3'h0, bandwidth_divider, bw_q[7:0]};
                `RSSF_ADDR_KEYED: prdata = {24'h000000, keyed_strength_value};
                `RSSF_ADDR_SPREAD: prdata = {8'h00, snr_q, packet_strength, spread_inst_q};
                `RSSF_ADDR_STATUS: prdata = {24'h000000, 1'b0, amp_gain_step, in_payload_q, bandwidth_reserved,
                                             st_q};
                default: begin
                    if (paddr >= `RSSF_ADDR_COEF && paddr < 12'h080 && paddr[1:0] == 2'b00) begin
                        prdata = {24'h000000, coef_q[paddr[5:2]*8 +: 8]};
                    end else begin
                        pslverr = 1'b1;
                    end
                end
            endcase
        end
    end

    // Gain step: higher level means less gain; level is -2*dBm so compare reversed
    always_comb begin
        if (in_level_neg2 >= gain_threshold_1) begin
            gain_d = 3'b001;
        end else if (in_level_neg2 >= gain_threshold_2) begin
            gain_d = 3'b010;
        end else if (in_level_neg2 >= gain_threshold_3) begin
            gain_d = 3'b011;
        end else if (in_level_neg2 >= gain_threshold_4) begin
            gain_d = 3'b100;
        end else if (in_level_neg2 >= gain_threshold_5) begin
            gain_d = 3'b110;
        end else begin
            gain_d = 3'b111;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            amp_gain_step <= 3'b001;
            amp_rel_gain_idx <= 3'h0;
        end else if (ce && lvl_vld) begin
            amp_gain_step <= gain_d;
            case (gain_d)
                3'b001: amp_rel_gain_idx <= 3'h0;
                3'b010: amp_rel_gain_idx <= 3'h1;
                3'b011: amp_rel_gain_idx <= 3'h2;
                3'b100: amp_rel_gain_idx <= 3'h3;
                3'b110: amp_rel_gain_idx <= 3'h4;
                default: amp_rel_gain_idx <= 3'h5;
            endcase
        end
    end

    // Offset is in dB, the value in half-dB units, so offset doubles
    // Strobe delayed one cycle so the average takes the sample just computed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            keyed_q <= 8'h00;
            keyed_vld_q <= 1'b0;
        end else if (ce) begin
            keyed_vld_q <= lvl_vld;
            if (lvl_vld) begin
                keyed_q <= in_level_neg2 + {{2{strength_comp_offset[4]}}, strength_comp_offset, 1'b0};
            end
        end
    end

    // Response time follows from averaging length and sample rate set by bandwidth
    rssf_avg u_keyed_avg (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .clr(cal_pend_q),
        .smp_vld(keyed_vld_q),
        .smp(keyed_q),
        .log_len(strength_avg_length),
        .avg_q(keyed_strength_value)
    );

    // Packet events come from another block's pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hdr_s1_q <= 2'b00;
            hdr_s2_q <= 2'b00;
            hdr_s3_q <= 2'b00;
            pre_s1_q <= 1'b0;
            pre_s2_q <= 1'b0;
        end else if (ce) begin
            hdr_s1_q <= {receive_done_event, header_ok_event};
            hdr_s2_q <= hdr_s1_q;
            hdr_s3_q <= hdr_s2_q;
            pre_s1_q <= preamble_ok;
            pre_s2_q <= pre_s1_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_payload_q <= 1'b0;
        end else if (ce) begin
            if (hdr_s2_q[0] && !hdr_s3_q[0]) begin
                in_payload_q <= 1'b1;
            end else if (hdr_s2_q[1] && !hdr_s3_q[1]) begin
                in_payload_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            spread_inst_q <= 8'h00;
            snr_q <= 8'h00;
        end else if (ce) begin
            spread_inst_q <= spread_inst;
            if (hdr_s2_q[1] && !hdr_s3_q[1]) begin
                snr_q <= packet_noise_ratio;
            end
        end
    end

    rssf_avg u_pkt_avg (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .clr(1'b0),
        .smp_vld(in_payload_q),
        .smp(spread_inst_q),
        .log_len(3'(`RSSF_PKT_AVG_LOG)),
        .avg_q(packet_strength)
    );

    // Receive sequencing with calibration taking priority
    always_comb begin
        st_d = st_q;
        case (st_q)
            rssf_pkg::RSSF_IDLE: begin
                if (ctrl_q[`RSSF_CTRL_CAL]) st_d = rssf_pkg::RSSF_CALIB;
                else if (ctrl_q[`RSSF_CTRL_RX_EN]) st_d = rssf_pkg::RSSF_ENABLED;
            end
            rssf_pkg::RSSF_ENABLED: begin
                if (ctrl_q[`RSSF_CTRL_CAL]) st_d = rssf_pkg::RSSF_CALIB;
                else if (!ctrl_q[`RSSF_CTRL_RX_EN]) st_d = rssf_pkg::RSSF_IDLE;
                else if (pre_s2_q || (keyed_strength_value != 8'h00 &&
                         keyed_strength_value <= gain_threshold_1)) st_d = rssf_pkg::RSSF_ACTIVE;
            end
            rssf_pkg::RSSF_ACTIVE: begin
                if (ctrl_q[`RSSF_CTRL_CAL]) st_d = rssf_pkg::RSSF_CALIB;
                else if (!ctrl_q[`RSSF_CTRL_RX_EN]) st_d = rssf_pkg::RSSF_IDLE;
            end
            rssf_pkg::RSSF_CALIB: begin
                if (cal_cnt_q == '0) st_d = rssf_pkg::RSSF_IDLE;
            end
            default: st_d = rssf_pkg::RSSF_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= rssf_pkg::RSSF_IDLE;
            cal_pend_q <= 1'b0;
            cal_cnt_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
            cal_pend_q <= (st_q != rssf_pkg::RSSF_CALIB) && ctrl_q[`RSSF_CTRL_CAL];
            if (st_q != rssf_pkg::RSSF_CALIB && st_d == rssf_pkg::RSSF_CALIB) begin
                cal_cnt_q <= ($clog2(`RSSF_CAL_CYC+1))'(`RSSF_CAL_CYC);
            end else if (cal_cnt_q != '0) begin
                cal_cnt_q <= cal_cnt_q - 1'b1;
            end
        end
    end
    assign rx_active = (st_q == rssf_pkg::RSSF_ACTIVE);

    // Bandwidth decode; divider times 2^(exp+2) divides the oscillator
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bandwidth_divider <= 5'd16;
            bandwidth_reserved <= 1'b0;
        end else if (ce) begin
            case (bandwidth_mantissa)
                2'b00: bandwidth_divider <= 5'd16;
                2'b01: bandwidth_divider <= 5'd20;
                2'b10: bandwidth_divider <= 5'd24;
                default: bandwidth_divider <= 5'd0;
            endcase
            bandwidth_reserved <= (bandwidth_mantissa == 2'b11) || (bandwidth_exponent == 3'h0);
        end
    end

    rssf_fir u_fir_i (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .in_vld(smp_vld),
        .in_smp(smp_i),
        .coefs(coef_q),
        .out_vld_q(f_vld_q),
        .out_q(filt_i)
    );
    rssf_fir u_fir_q (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .in_vld(smp_vld),
        .in_smp(smp_q),
        .coefs(coef_q),
        .out_vld_q(),
        .out_q(filt_q)
    );
    assign filt_vld = f_vld_q;
endmodule

// >>> testbench/rssf_chk.sv
// Concurrent checks on the ports of rssf_top.
// Assumes one clock domain with a synchronous active-high reset.
module rssf_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    input wire logic smp_vld,
    input wire logic filt_vld,
    input wire logic [2:0] amp_gain_step,
    input wire logic [2:0] amp_rel_gain_idx,
    input wire logic [2:0] bandwidth_exponent,
    input wire logic [4:0] bandwidth_divider,
    input wire logic bandwidth_reserved
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_smp_taken;
        ce && smp_vld;
    endsequence
    sequence s_no_smp;
        ce && !smp_vld;
    endsequence
    AST_GAIN_LEGAL: assert property (amp_gain_step inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7})
        else $error("gain step outside the six codes");
    // Code 101 is skipped, so the index-to-code map is not linear
    AST_GAIN_IDX: assert property (amp_gain_step == amp_rel_gain_idx + ((amp_rel_gain_idx < 3'h4) ? 3'h1 : 3'h2))
        else $error("gain step and relative gain disagree");
    AST_RST_VAL: assert property ($fell(rst) |-> amp_gain_step == 3'h1 && bandwidth_divider == 5'h10)
        else $error("wrong gain or divider after reset");
    AST_DIV_LEGAL: assert property (bandwidth_divider inside {5'h00, 5'h10, 5'h14, 5'h18})
        else $error("bandwidth divider not 16, 20 or 24");
    // Flag and divider are registered, the exponent is not: compare with last cycle's
    AST_BW_RSV: assert property (bandwidth_reserved ==
        (bandwidth_divider == 5'h00 || $past(bandwidth_exponent) == 3'h0))
        else $error("reserved bandwidth flag wrong");
    AST_FILT_LAT: assert property (s_smp_taken |=> filt_vld)
        else $error("no filter output one cycle after a sample");
    AST_FILT_ONLY: assert property (s_no_smp |=> !filt_vld)
        else $error("filter output without a sample");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable && !pwrite)
        else $error("error response outside a read access phase");
endmodule

bind rssf_top rssf_chk chk (.sys_clk, .rst, .ce, .psel, .penable, .pwrite, .pslverr, .smp_vld, .filt_vld,
    .amp_gain_step, .amp_rel_gain_idx, .bandwidth_exponent, .bandwidth_divider, .bandwidth_reserved);

// >>> testbench/rssf_fe_model.sv
// Front-end stand-in: level strobes, spread value, packet events, I/Q samples.
// Assumes its tasks are called from one bench process.
module rssf_fe_model (
    input wire logic sys_clk,
    output logic lvl_vld,
    output logic [7:0] in_level_neg2,
    output logic [7:0] spread_inst,
    output logic [7:0] packet_noise_ratio,
    output logic preamble_ok,
    output logic header_ok_event,
    output logic receive_done_event,
    output logic smp_vld,
    output logic signed [11:0] smp_i,
    output logic signed [11:0] smp_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {lvl_vld, in_level_neg2, preamble_ok, header_ok_event, receive_done_event} = '0;
        {smp_vld, smp_i, smp_q} = '0;
        spread_inst = 8'h33;
        packet_noise_ratio = 8'hf8;
    end
    // Stale data is inverted so nothing relies on a held value
    task send_level(input logic [7:0] l);
        @(posedge sys_clk);
        lvl_vld <= 1'b1;
        in_level_neg2 <= l;
        @(posedge sys_clk);
        lvl_vld <= 1'b0;
        in_level_neg2 <= ~l;
    endtask
    task send_smp(input logic signed [11:0] i, input logic signed [11:0] q);
        @(posedge sys_clk);
        smp_vld <= 1'b1;
        smp_i <= i;
        smp_q <= q;
        @(posedge sys_clk);
        smp_vld <= 1'b0;
        smp_i <= ~i;
        smp_q <= ~q;
    endtask
    // Header opens the payload window, done closes it and carries the ratio
    task packet(input logic [7:0] snr, input int len);
        @(posedge sys_clk);
        header_ok_event <= 1'b1;
        repeat (len) @(posedge sys_clk);
        header_ok_event <= 1'b0;
        receive_done_event <= 1'b1;
        packet_noise_ratio <= snr;
        repeat (4) @(posedge sys_clk);
        receive_done_event <= 1'b0;
    endtask
    // Held long enough for the two-stage synchroniser
    task pulse_preamble();
        @(posedge sys_clk);
        preamble_ok <= 1'b1;
        repeat (4) @(posedge sys_clk);
        preamble_ok <= 1'b0;
    endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for rssf_top: APB master tasks and front-end model.
// Assumes a 200 MHz sys_clk and a zero-wait-state slave.
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic rerr, lvl_vld, preamble_ok, header_ok_event, receive_done_event, smp_vld, filt_vld;
    logic bandwidth_reserved, rx_active;
    logic [7:0] in_level_neg2, spread_inst, packet_noise_ratio;
    logic signed [11:0] smp_i, smp_q, filt_i, filt_q;
    logic [2:0] amp_gain_step, amp_rel_gain_idx, bandwidth_exponent;
    logic [4:0] bandwidth_divider;
    int mismatches = 0;
    int n_tests = 0;
    logic [7:0] lv [10] = '{8'ha0, 8'h9f, 8'h80, 8'h7f, 8'h60, 8'h5f, 8'h40, 8'h3f, 8'h20, 8'h1f};
    logic [2:0] gc [10] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h6, 3'h6, 3'h7};
    logic [4:0] ofs [2] = '{5'h10, 5'h0f};
    logic [7:0] kexp [2] = '{8'h40, 8'h7e};
    logic [4:0] dv [4] = '{5'h10, 5'h14, 5'h18, 5'h00};
    rssf_fe_model fe (.sys_clk, .lvl_vld, .in_level_neg2, .spread_inst, .packet_noise_ratio, .preamble_ok,
        .header_ok_event, .receive_done_event, .smp_vld, .smp_i, .smp_q);
    rssf_top dut (.sys_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .lvl_vld, .in_level_neg2, .spread_inst, .packet_noise_ratio, .preamble_ok, .header_ok_event,
        .receive_done_event, .smp_vld, .smp_i, .smp_q, .amp_gain_step, .amp_rel_gain_idx, .filt_vld, .filt_i,
        .filt_q, .bandwidth_exponent, .bandwidth_divider, .bandwidth_reserved, .rx_active);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        apb(0, 12'h00c, 0);
        `CHK(rdat[12:0], 13'h1005)
        for (int m = 0; m < 4; m++) begin
            for (int x = 0; x < 8; x++) begin
                apb(1, 12'h00c, {26'h0, 2'(m), 1'b0, 3'(x)});
                // Decode is registered one cycle behind the register write
                repeat (2) @(negedge sys_clk);
                `CHK(bandwidth_divider, dv[m])
                `CHK(bandwidth_reserved, 1'(m == 3 || x == 0))
            end
        end
        apb(1, 12'h00c, 32'h15);
        repeat (2) @(negedge sys_clk);
        `CHK(bandwidth_divider, 5'h14)
        `CHK(bandwidth_reserved, 1'b0)
        apb(1, 12'h000, 32'h1);
        apb(0, 12'h018, 0);
        `CHK(rdat[1:0], 2'b01)
        `CHK(rx_active, 1'b0)
        fe.pulse_preamble();
        repeat (4) @(posedge sys_clk);
        `CHK(rx_active, 1'b1)
        apb(0, 12'h014, 0);
        `CHK(rdat[7:0], 8'h33)
        apb(1, 12'h000, 32'h0);
        repeat (2) @(negedge sys_clk);
        `CHK(rx_active, 1'b0)
        // Output sums the delay line before the new sample shifts in
        for (int k = 0; k < 18; k++) begin
            fe.send_smp((k == 0) ? 12'sh100 : 12'sh000, (k == 0) ? -12'sh100 : 12'sh000);
            @(negedge sys_clk);
            `CHK(filt_i, (k >= 1 && k <= 16) ? 12'sh020 : 12'sh000)
            `CHK(filt_q, (k >= 1 && k <= 16) ? -12'sh020 : 12'sh000)
        end
        apb(1, 12'h004, 32'ha080_6040);
        apb(1, 12'h008, 32'h20);
        for (int i = 0; i < 10; i++) begin
            fe.send_level(lv[i]);
            repeat (3) @(posedge sys_clk);
            `CHK(amp_gain_step, gc[i])
        end
        // Writes while the clock enable is low are lost
        ce <= 1'b0;
        apb(1, 12'h004, 32'h0);
        ce <= 1'b1;
        apb(0, 12'h004, 0);
        `CHK(rdat, 32'ha080_6040)
        for (int j = 0; j < 2; j++) begin
            apb(1, 12'h000, {19'h0, ofs[j], 8'h01});
            repeat (12) fe.send_level(8'h60);
            apb(0, 12'h010, 0);
            `CHK(rdat[7:0], kexp[j])
        end
        fe.packet(8'hf8, 200);
        apb(0, 12'h014, 0);
        `CHK(rdat[23:0], 24'hf8_33_33)
        `CHK(-157 + int'(rdat[15:8]) + int'($signed(rdat[23:16])) / 4, -108)
        `CHK(-108 - int'(rdat[15:8]) - int'($signed(rdat[23:16])) / 4, -157)
        fe.packet(8'h04, 20);
        apb(0, 12'h014, 0);
        `CHK(rdat[23:0], 24'h04_33_33)
        `CHK(-164 + (16 * int'(rdat[15:8])) / 15, -110)
        apb(1, 12'h000, 32'h3);
        apb(0, 12'h018, 0);
        `CHK(rdat[1:0], 2'b10)
        apb(0, 12'h010, 0);
        `CHK(rdat[7:0], 8'h00)
        repeat (250) @(posedge sys_clk);
        apb(0, 12'h018, 0);
        `CHK(rdat[1:0], 2'b01)
        apb(0, 12'h020, 0);
        `CHK(rerr, 1'b1)
        summarize();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        summarize();
    end
endmodule
